// >>> design/loop_cfg.sv
// register file and loop control for frequency offset compensation and bit sync
`timescale 1ns/100ps
module loop_cfg
	import loop_cfg_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// serial port register access, already in this clock domain
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// demodulator status
	input wire logic carrier_sense,
	input wire logic sync_found,
	// loop settings
	output loop_ctl_s loop_ctl
);
	logic [7:0] freq_offset_comp_config;
	logic [7:0] bit_sync_config;
	logic carrier_seen;
	loop_ctl_s next_loop_ctl;
	logic [7:0] next_rdata;

	// multiplier for a two-bit gain field: 00 gives 1, 11 gives 4
	function automatic logic [2:0] gain_mult(input logic [1:0] f);
		gain_mult = {1'b0, f} + 3'h1;
	endfunction : gain_mult

	// settings that the register reset values give with no carrier and no sync yet
	localparam loop_ctl_s ctl_reset = '{
		freeze: freq_reset[gate_bit],
		freq_gain: {gain_mult(freq_reset[pre_k_lo +: 2]), 1'b0},
		freq_sat: sat_e'(freq_reset[sat_lo +: 2]),
		ki_mult: gain_mult(sync_reset[ki_lo +: 2]),
		kp_mult: gain_mult(sync_reset[kp_lo +: 2])
	};

	// ==========================================
	// registers
	// reserved bits never store, so they read zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_offset_comp_config <= freq_reset;
		end else if (wr_en && addr == freq_offset_comp_config_addr) begin
			freq_offset_comp_config <= wdata & freq_writable;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_sync_config <= sync_reset;
		end else if (wr_en && addr == bit_sync_config_addr) begin
			bit_sync_config <= wdata;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (addr)
			freq_offset_comp_config_addr: next_rdata = freq_offset_comp_config;
			bit_sync_config_addr: next_rdata = bit_sync_config;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data from a flop, so it stands one edge after the address
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ==========================================
	// carrier gate: once carrier is seen the loops run until carrier sense and sync_found are both low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			carrier_seen <= 1'b0;
		end else if (carrier_sense) begin
			carrier_seen <= 1'b1;
		end else if (!sync_found) begin
			carrier_seen <= 1'b0;
		end
	end

	// ==========================================
	// loop settings, registered so the loops see clean values
	always_comb begin
		next_loop_ctl.freeze = freq_offset_comp_config[gate_bit] && !carrier_seen && !carrier_sense;
		next_loop_ctl.freq_gain = {gain_mult(freq_offset_comp_config[pre_k_lo +: 2]), 1'b0};
		if (sync_found && freq_offset_comp_config[post_k_bit]) begin
			next_loop_ctl.freq_gain = half_k;
		end
		next_loop_ctl.freq_sat = sat_e'(freq_offset_comp_config[sat_lo +: 2]);
		next_loop_ctl.ki_mult = gain_mult(bit_sync_config[ki_lo +: 2]);
		next_loop_ctl.kp_mult = gain_mult(bit_sync_config[kp_lo +: 2]);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_ctl <= ctl_reset;
		end else begin
			loop_ctl <= next_loop_ctl;
		end
	end

	// ==========================================
	// checks: carrier gate

	// loops hold while the gate is set and no carrier has been seen
	a_gate_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
		freq_offset_comp_config[gate_bit] && !carrier_sense && !carrier_seen
		|=> loop_ctl.freeze)
		else $error("loops not frozen without carrier");

	// carrier sense opens the gate on the next edge
	a_gate_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carrier_sense
		|=> !loop_ctl.freeze)
		else $error("loops frozen with carrier");

	// with the gate bit clear the loops never freeze
	a_gate_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!freq_offset_comp_config[gate_bit]
		|=> !loop_ctl.freeze)
		else $error("loops frozen with gate off");

	// carrier sense is remembered for the rest of the packet
	a_carrier_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carrier_sense
		|=> carrier_seen)
		else $error("carrier not remembered");

	// a remembered carrier keeps the loops running when carrier sense drops
	a_carrier_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carrier_seen
		|=> !loop_ctl.freeze)
		else $error("loops frozen after carrier seen");

	// ==========================================
	// checks: loop gains and saturation

	// before sync the gain is the field plus one, in units of K
	a_pre_gain: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!sync_found
		|=> loop_ctl.freq_gain == {$past(freq_offset_comp_config[pre_k_lo +: 2]) + 3'h1, 1'b0})
		else $error("pre-sync gain wrong");

	// after sync with the post bit clear the pre-sync gain stays
	a_post_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sync_found && !freq_offset_comp_config[post_k_bit]
		|=> loop_ctl.freq_gain == {$past(freq_offset_comp_config[pre_k_lo +: 2]) + 3'h1, 1'b0})
		else $error("post-sync gain not kept");

	// after sync with the post bit set the gain drops to K/2
	a_post_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sync_found && freq_offset_comp_config[post_k_bit]
		|=> loop_ctl.freq_gain == half_k)
		else $error("post-sync gain not half");

	// saturation code passes straight through to the loop
	a_sat_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1
		|=> loop_ctl.freq_sat == $past(freq_offset_comp_config[sat_lo +: 2]))
		else $error("saturation wrong");

	// integral gain multiplier is the field plus one
	a_ki_gain: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1
		|=> loop_ctl.ki_mult == $past(bit_sync_config[ki_lo +: 2]) + 3'h1)
		else $error("integral gain wrong");

	// proportional gain multiplier is the field plus one
	a_kp_gain: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1
		|=> loop_ctl.kp_mult == $past(bit_sync_config[kp_lo +: 2]) + 3'h1)
		else $error("proportional gain wrong");

	// ==========================================
	// checks: register access

	// reserved bits never hold a one, whatever was written
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en && addr == freq_offset_comp_config_addr
		|=> (freq_offset_comp_config & ~freq_writable) == 8'h00)
		else $error("reserved bits stored");

	// writable bits of the frequency register take the write data
	a_freq_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en && addr == freq_offset_comp_config_addr
		|=> freq_offset_comp_config == ($past(wdata) & freq_writable))
		else $error("frequency register write lost");

	// the bit sync register stores all eight bits
	a_sync_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en && addr == bit_sync_config_addr
		|=> bit_sync_config == $past(wdata))
		else $error("bit sync register write lost");

	// read data shows the frequency register one edge after its address
	a_read_freq: assert property (@(posedge ref_clk) disable iff (!rst_n)
		addr == freq_offset_comp_config_addr
		|=> rdata == $past(freq_offset_comp_config))
		else $error("frequency register read wrong");

	// read data shows the bit sync register one edge after its address
	a_read_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
		addr == bit_sync_config_addr
		|=> rdata == $past(bit_sync_config))
		else $error("bit sync register read wrong");

	// any other address reads zero
	a_read_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
		addr != freq_offset_comp_config_addr && addr != bit_sync_config_addr
		|=> rdata == 8'h00)
		else $error("unmapped read not zero");

	// main scenarios
	c_gate_open: cover property (@(posedge ref_clk) disable iff (!rst_n) loop_ctl.freeze ##1 !loop_ctl.freeze);
	c_post_sync: cover property (@(posedge ref_clk) disable iff (!rst_n) loop_ctl.freq_gain == half_k);
	c_sat_off: cover property (@(posedge ref_clk) disable iff (!rst_n) loop_ctl.freq_sat == sat_off);
	c_carrier_held: cover property (@(posedge ref_clk) disable iff (!rst_n) carrier_seen && !carrier_sense);
	c_refreeze: cover property (@(posedge ref_clk) disable iff (!rst_n) !loop_ctl.freeze ##1 loop_ctl.freeze);
endmodule : loop_cfg

// >>> design/loop_cfg_pkg.sv
// constants and carriers for the frequency offset and bit sync configuration block
//
// Notes on behaviour
// - with the carrier gate set, both loops stay frozen until carrier sense rises.
// - before sync, frequency loop gain is (field+1) times K, field reset 10.
// - after sync, bit 2 set gives K/2, clear keeps the pre-sync gain.
// - offset saturation field: 00 off, 01 bw/8, 10 bw/4, 11 bw/2.
// - before sync, recovery integral gain is (field+1) times K_I, reset 01.
// - before sync, recovery proportional gain from bits 5:4, reset 10, 00 is K_P.
// - frequency register bits 7:6 are reserved, read zero, writes have no effect.
package loop_cfg_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] freq_offset_comp_config_addr = 8'h19;
	localparam logic [7:0] bit_sync_config_addr = 8'h1a;
	localparam logic [7:0] freq_reset = 8'h36;
	localparam logic [7:0] sync_reset = 8'h6c;
	localparam logic [7:0] freq_writable = 8'h3f;
	// ==========================================
	// field positions
	localparam int gate_bit = 5;
	localparam int pre_k_lo = 3;
	localparam int post_k_bit = 2;
	localparam int sat_lo = 0;
	localparam int ki_lo = 6;
	localparam int kp_lo = 4;
	// ==========================================
	// loop gain in units of K/2: 2 is K, 8 is 4K, 1 is K/2
	typedef logic [3:0] gain_t;
	localparam gain_t half_k = 4'h1;
	typedef enum logic [1:0] {
		sat_off = 2'b00,
		sat_eighth = 2'b01,
		sat_quarter = 2'b10,
		sat_half = 2'b11
	} sat_e;
	// settings handed to the demodulator loops
	typedef struct packed {
		logic freeze;
		gain_t freq_gain;
		sat_e freq_sat;
		logic [2:0] ki_mult;
		logic [2:0] kp_mult;
	} loop_ctl_s;
endpackage : loop_cfg_pkg

// >>> verification/tb_top.sv
// self-checking bench for the loop configuration registers
`timescale 1ns/100ps
module tb_top;
	import loop_cfg_pkg::*;
	logic ref_clk, rst_n, wr_en, carrier_sense, sync_found;
	logic [7:0] addr, wdata, rdata;
	loop_ctl_s loop_ctl;
	int errors, checked, cycles;
	// ==========================================
	// clock and hang guard, the whole run needs well under 200 cycles
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 500) begin
			errors++;
			report_and_stop();
		end
	end
	loop_cfg loop_cfg_i (.ref_clk(ref_clk), .rst_n(rst_n), .wr_en(wr_en), .addr(addr), .wdata(wdata),
		.rdata(rdata), .carrier_sense(carrier_sense), .sync_found(sync_found), .loop_ctl(loop_ctl));
	// ==========================================
	// access tasks and comparison
	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask : chk
	// one-cycle strobe, then wait the extra edge before loop_ctl follows
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : wr
	// read data comes from a flop, so it stands one edge after the address
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		@(posedge ref_clk);
		#1;
	endtask : rd
	task idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : idle
	function automatic loop_ctl_s mk(logic f, gain_t g, logic [1:0] s, logic [2:0] ki, logic [2:0] kp);
		mk = {f, g, s, ki, kp};
	endfunction : mk
	task report_and_stop;
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// ==========================================
	// test sequence
	initial begin
		rst_n = 1'b0;
		wr_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		carrier_sense = 1'b0;
		sync_found = 1'b0;
		errors = 0;
		checked = 0;
		cycles = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(freq_offset_comp_config_addr);
		chk("freq_reg", 16'(rdata), 16'h0036);
		rd(bit_sync_config_addr);
		chk("sync_reg", 16'(rdata), 16'h006c);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b1, 4'h6, 2'h2, 3'h2, 3'h3)));
		rd(8'h00);
		chk("unmapped", 16'(rdata), 16'h0000);
		// every gain and saturation code, reserved bits written high each time
		for (int k = 0; k < 4; k++) begin
			wr(freq_offset_comp_config_addr, 8'hc0 | 8'(k * 9));
			rd(freq_offset_comp_config_addr);
			chk("freq_reg", 16'(rdata), 16'(k * 9));
			// recovery gains still hold the previous pass's write, or reset values on the first
			chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, 4'(2 * k + 2), 2'(k),
				3'(k == 0 ? 2 : k), 3'(k == 0 ? 3 : k))));
			wr(bit_sync_config_addr, 8'(k * 80));
			chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, 4'(2 * k + 2), 2'(k), 3'(k + 1), 3'(k + 1))));
		end
		// after sync: clear post bit keeps the pre-sync gain, set bit drops it to K/2
		@(posedge ref_clk);
		sync_found <= 1'b1;
		idle(2);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, 4'h8, 2'h3, 3'h4, 3'h4)));
		wr(freq_offset_comp_config_addr, 8'h1f);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, half_k, 2'h3, 3'h4, 3'h4)));
		// carrier gate holds the loops until carrier sense rises
		@(posedge ref_clk);
		sync_found <= 1'b0;
		wr(freq_offset_comp_config_addr, 8'h3f);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b1, 4'h8, 2'h3, 3'h4, 3'h4)));
		@(posedge ref_clk);
		carrier_sense <= 1'b1;
		idle(2);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, 4'h8, 2'h3, 3'h4, 3'h4)));
		// carrier dropping inside a packet keeps the loops running, losing sync as well refreezes
		@(posedge ref_clk);
		sync_found <= 1'b1;
		@(posedge ref_clk);
		carrier_sense <= 1'b0;
		idle(2);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, half_k, 2'h3, 3'h4, 3'h4)));
		@(posedge ref_clk);
		sync_found <= 1'b0;
		idle(2);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b1, 4'h8, 2'h3, 3'h4, 3'h4)));
		// amplitude keyed setup: software turns offset saturation off
		wr(freq_offset_comp_config_addr, 8'h1c);
		chk("loop_ctl", 16'(loop_ctl), 16'(mk(1'b0, 4'h8, 2'h0, 3'h4, 3'h4)));
		report_and_stop();
	end
endmodule : tb_top
